// *** src/art_pkg.sv ***
// Package of constants, types and register layout for the antenna tuner
package art_pkg;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] ART_OFS_CMD     = 8'h00;
   localparam logic [7:0] ART_OFS_CAL     = 8'h04;
   localparam logic [7:0] ART_OFS_EXTTRIM = 8'h08;
   localparam logic [7:0] ART_OFS_ADC     = 8'h0c;
   localparam logic [7:0] ART_OFS_STAT    = 8'h10;
   localparam logic [7:0] ART_OFS_IRQ     = 8'h14;
   localparam logic [7:0] ART_OFS_MASK    = 8'h18;

   // ==========================================================
   // Field positions
   localparam int ART_CMD_CHECK_BIT  = 0;
   localparam int ART_CMD_CAL_BIT    = 1;
   localparam int ART_CAL_ERR_BIT    = 4;
   localparam int ART_EXT_SEL_BIT    = 4;
   localparam int ART_STAT_BUSY_BIT  = 0;
   localparam int ART_STAT_COMP_BIT  = 1;
   localparam int ART_IRQ_CAL_BIT    = 0;
   localparam int ART_IRQ_CHK_BIT    = 1;
   localparam int ART_IRQ_ERR_BIT    = 2;

   // ==========================================================
   // Widths and reset values
   localparam int ART_TRIM_W = 4;
   localparam int ART_ADC_W  = 8;
   localparam int ART_IRQ_W  = 3;
   localparam logic [ART_TRIM_W-1:0] ART_TRIM_RST = 4'h0;
   localparam logic [ART_IRQ_W-1:0]  ART_MASK_RST = 3'h0;

   // ==========================================================
   // Tuning figures
   localparam int ART_CLK_MHZ      = 100;
   localparam int ART_SETTLE_US    = 10;
   localparam int ART_SETTLE_CYC   = ART_SETTLE_US * ART_CLK_MHZ;
   localparam logic [ART_ADC_W-1:0] ART_MID_HI = 8'h80;
   localparam logic [ART_ADC_W-1:0] ART_MID_LO = 8'h7f;

   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      ART_IDLE   = 3'b000,
      ART_CHK    = 3'b001,
      ART_CAL0   = 3'b010,
      ART_CALW   = 3'b011,
      ART_CALS   = 3'b100
   } art_state_e;

   typedef struct packed {
      logic                  cyc;
      logic                  stb;
      logic                  we;
      logic [3:0]            sel;
      logic [7:0]            adr;
      logic [31:0]           dat;
   } art_wb_req_s;

   typedef struct packed {
      logic                  ack;
      logic [31:0]           dat;
   } art_wb_rsp_s;

   typedef struct packed {
      logic                  start;
      logic                  done;
      logic [ART_ADC_W-1:0]  data;
   } art_adc_s;

endpackage : art_pkg

// *** src/art_settle_timer.sv ***
// Settle timer counting the wait before each comparator sample
`timescale 1ns/10ps
module art_settle_timer
   import art_pkg::*;
#(
   parameter int CYCLES = ART_SETTLE_CYC
) (
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic rst_in,
   // Control
   input  wire logic start_in,
   output logic      done_out
);
   // ==========================================================
   // State
   typedef struct packed {
      logic [15:0] cnt;
      logic        run;
      logic        done;
   } art_tmr_s;

   art_tmr_s s_q, s_d;

   always_comb begin
      s_d      = s_q;
      s_d.done = 1'b0;
      if (start_in) begin
         s_d.run = 1'b1;
         s_d.cnt = 16'(CYCLES - 1);
      end else if (s_q.run) begin
         if (s_q.cnt == 16'h0000) begin
            s_d.run  = 1'b0;
            s_d.done = 1'b1;
         end else begin
            s_d.cnt = s_q.cnt - 16'h0001;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign done_out = s_q.done;
endmodule // art_settle_timer

// *** src/art_wb_slave.sv ***
// Classic Wishbone slave front end: one-cycle ack pulse per request
`timescale 1ns/10ps
module art_wb_slave
   import art_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   // Bus request
   input  wire art_wb_req_s req_in,
   // Decoded access strobes
   output logic             wr_out,
   output logic             rd_out,
   output logic             ack_out
);
   // ==========================================================
   // State
   typedef struct packed {
      logic ack;
   } art_wbs_s;

   art_wbs_s s_q, s_d;
   logic     hit;

   // Ack falls after one cycle and blocks the next; a request still held is taken again every other cycle
   always_comb begin
      hit     = req_in.cyc && req_in.stb && !s_q.ack;
      s_d.ack = hit;
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign wr_out  = hit && req_in.we;
   assign rd_out  = hit && !req_in.we;
   assign ack_out = s_q.ack;
endmodule // art_wb_slave

// *** src/art_tuner.sv ***
// Antenna resonance tuner: check, automatic trim search, external trim
//
// Summary of operation
// (R1) Phase detector compares drive and sense signals; 90 deg means tuned.
// (R2) Check command routes phase output to ADC, relative mode, 0.468 deg/LSB.
// (R3) Tuned antenna converts to mid-range, 0x80 or 0x7f.
// (R4) Result above 0x80 means resonance high; below 0x7f means low.
// (R5) Equal-weight switches of both pad groups share one control bit.
// (R6) Calibration uses comparator: high above target, low below.
// (R7) Calibration starts with every trim switch off.
// (R8) Comparator low at start sets error flag and ends calibration.
// (R9) Comparator high: step code up from LSB, resample 10 us later.
// (R10) Stop on comparator low; keep that code as the result.
// (R11) All switches on and comparator still high sets error flag.
// (R12) Readable result holds four switch states and error flag.
// (R13) External select high drives switches from host trim code; here the search code still drives them during calibration.
// (R14) Host may trim externally using checks or amplitude readings.
// (R15) Code and error flag hold until next calibration or reset.
`timescale 1ns/10ps
module art_tuner
   import art_pkg::*;
#(
   parameter int SETTLE_CYC = ART_SETTLE_CYC
) (
   // Clock and reset
   input  wire logic                  REF_CLK_IN,
   input  wire logic                  SYS_RST_IN,
   // Wishbone
   input  wire logic                  WB_CYC_IN,
   input  wire logic                  WB_STB_IN,
   input  wire logic                  WB_WE_IN,
   input  wire logic [3:0]            WB_SEL_IN,
   input  wire logic [7:0]            WB_ADR_IN,
   input  wire logic [31:0]           WB_DAT_IN,
   output logic [31:0]                WB_DAT_OUT,
   output logic                       WB_ACK_OUT,
   // Phase detector analog interface
   input  wire logic                  PHASE_COMP_IN,
   output logic                       ADC_PHASE_SEL_OUT,
   output logic                       ADC_REL_MODE_OUT,
   output logic                       ADC_START_OUT,
   input  wire logic                  ADC_DONE_IN,
   input  wire logic [ART_ADC_W-1:0]  ADC_DATA_IN,
   // Trim pads
   output logic [ART_TRIM_W-1:0]      TRIM_GROUP_A_SWITCHES_OUT,
   output logic [ART_TRIM_W-1:0]      TRIM_GROUP_B_SWITCHES_OUT,
   // Interrupt
   output logic                       IRQ_OUT
);
   // ==========================================================
   // Bus front end
   art_wb_req_s req;
   art_adc_s    adc;
   logic        bus_wr;
   logic        bus_rd;
   logic        bus_ack;
   logic        tmr_start;
   logic        tmr_done;

   always_comb begin
      req.cyc   = WB_CYC_IN;
      req.stb   = WB_STB_IN;
      req.we    = WB_WE_IN;
      req.sel   = WB_SEL_IN;
      req.adr   = WB_ADR_IN;
      req.dat   = WB_DAT_IN;
      adc.start = 1'b0;
      adc.done  = ADC_DONE_IN;
      adc.data  = ADC_DATA_IN;
   end

   art_wb_slave u_bus (
      .clk_in  (REF_CLK_IN),
      .rst_in  (SYS_RST_IN),
      .req_in  (req),
      .wr_out  (bus_wr),
      .rd_out  (bus_rd),
      .ack_out (bus_ack)
   );

   art_settle_timer #(
      .CYCLES (SETTLE_CYC)
   ) u_tmr (
      .clk_in   (REF_CLK_IN),
      .rst_in   (SYS_RST_IN),
      .start_in (tmr_start),
      .done_out (tmr_done)
   );

   // ==========================================================
   // State
   typedef struct packed {
      art_state_e              st;
      logic [ART_TRIM_W-1:0]   code;
      logic [ART_TRIM_W-1:0]   cal_code;
      logic                    cal_err;
      logic [ART_TRIM_W-1:0]   ext_code;
      logic                    ext_sel;
      logic [ART_ADC_W-1:0]    adc_res;
      logic [ART_IRQ_W-1:0]    irq;
      logic [ART_IRQ_W-1:0]    mask;
      logic                    adc_start;
      logic                    tmr_go;
      logic [ART_TRIM_W-1:0]   sw;
      logic                    irq_out;
      logic [31:0]             rdat;
      logic                    comp;
      logic                    route;
   } art_top_s;

   art_top_s s_q, s_d;
   logic [ART_IRQ_W-1:0] ev;
   logic                 lane0;
   logic                 is_hi;
   logic                 is_lo;
   logic                 cmd_cal;
   logic                 cmd_chk;
   logic                 wr_ext;
   logic                 wr_mask;
   logic                 wr_irq;
   logic                 in_cal;

   always_comb begin
      s_d           = s_q;
      ev            = '0;
      s_d.adc_start = 1'b0;
      s_d.tmr_go    = 1'b0;
      s_d.comp      = PHASE_COMP_IN;
      lane0         = bus_wr && WB_SEL_IN[0];
      // Above/below classification of the latest check result
      is_hi = s_q.adc_res > ART_MID_HI; // see (R4)
      is_lo = s_q.adc_res < ART_MID_LO; // see (R4)

      // =======================================================
      // Access decode; calibrate wins when both command bits are set
      cmd_cal = lane0 && WB_ADR_IN == ART_OFS_CMD &&
                WB_DAT_IN[ART_CMD_CAL_BIT];
      cmd_chk = lane0 && WB_ADR_IN == ART_OFS_CMD &&
                WB_DAT_IN[ART_CMD_CHECK_BIT] && !cmd_cal;
      wr_ext  = lane0 && WB_ADR_IN == ART_OFS_EXTTRIM;
      wr_mask = lane0 && WB_ADR_IN == ART_OFS_MASK;
      wr_irq  = lane0 && WB_ADR_IN == ART_OFS_IRQ;
      // Search code owns the pads for the whole calibration
      in_cal  = s_q.st == ART_CAL0 || s_q.st == ART_CALW ||
                s_q.st == ART_CALS;

      // =======================================================
      // Sequencer
      case (s_q.st)
         ART_IDLE: begin
            if (cmd_cal) begin
               s_d.code   = '0; // see (R7)
               s_d.tmr_go = 1'b1;
               s_d.st     = ART_CAL0;
            end else if (cmd_chk) begin
               s_d.adc_start = 1'b1; // see (R2)
               s_d.st        = ART_CHK;
            end
         end
         ART_CHK: begin
            // Phase output sits on ADC in relative mode; see (R1)
            if (adc.done) begin
               s_d.adc_res = adc.data; // see (R3)
               ev[ART_IRQ_CHK_BIT] = 1'b1;
               s_d.st = ART_IDLE;
            end
         end
         ART_CAL0: begin
            // Initial sample after switches settle open
            if (tmr_done) begin
               if (!s_q.comp) begin
                  s_d.cal_code = '0;
                  s_d.cal_err  = 1'b1; // see (R8)
                  ev[ART_IRQ_ERR_BIT] = 1'b1;
                  ev[ART_IRQ_CAL_BIT] = 1'b1;
                  s_d.st = ART_IDLE;
               end else begin
                  s_d.code   = s_q.code + 4'h1; // see (R9)
                  s_d.tmr_go = 1'b1;
                  s_d.st     = ART_CALW;
               end
            end
         end
         ART_CALW: begin
            if (tmr_done) begin
               s_d.st = ART_CALS;
            end
         end
         ART_CALS: begin
            if (!s_q.comp) begin
               s_d.cal_code = s_q.code; // see (R10)
               s_d.cal_err  = 1'b0;
               ev[ART_IRQ_CAL_BIT] = 1'b1;
               s_d.st = ART_IDLE;
            end else if (&s_q.code) begin
               s_d.cal_code = s_q.code;
               s_d.cal_err  = 1'b1; // see (R11)
               ev[ART_IRQ_ERR_BIT] = 1'b1;
               ev[ART_IRQ_CAL_BIT] = 1'b1;
               s_d.st = ART_IDLE;
            end else begin
               s_d.code   = s_q.code + 4'h1; // see (R9)
               s_d.tmr_go = 1'b1;
               s_d.st     = ART_CALW;
            end
         end
         default: begin
            s_d.st = ART_IDLE;
         end
      endcase

      // =======================================================
      // Register writes
      if (wr_ext) begin
         s_d.ext_code = WB_DAT_IN[ART_TRIM_W-1:0];
         s_d.ext_sel  = WB_DAT_IN[ART_EXT_SEL_BIT];
      end
      if (wr_mask) begin
         s_d.mask = WB_DAT_IN[ART_IRQ_W-1:0];
      end
      // Write one clears; a new event in the same cycle wins
      if (wr_irq) begin
         s_d.irq = s_q.irq & ~WB_DAT_IN[ART_IRQ_W-1:0];
      end
      s_d.irq = s_d.irq | ev;
      s_d.irq_out = |(s_d.irq & s_d.mask);
      // Phase detector stays on the converter until the result lands
      s_d.route   = (s_d.st == ART_CHK); // see (R2)

      // =======================================================
      // Switch drive: search code while calibrating, else host code if selected, else result
      if (in_cal) begin
         s_d.sw = s_d.code;
      end else if (s_d.ext_sel) begin
         s_d.sw = s_d.ext_code; // see (R13)
      end else begin
         s_d.sw = s_d.cal_code; // see (R15)
      end

      // =======================================================
      // Read mux
      s_d.rdat = '0;
      if (bus_rd) begin
         case (WB_ADR_IN)
            ART_OFS_CAL: begin
               s_d.rdat[ART_TRIM_W-1:0]  = s_q.cal_code; // see (R12)
               s_d.rdat[ART_CAL_ERR_BIT] = s_q.cal_err;
            end
            ART_OFS_EXTTRIM: begin
               s_d.rdat[ART_TRIM_W-1:0]  = s_q.ext_code;
               s_d.rdat[ART_EXT_SEL_BIT] = s_q.ext_sel;
            end
            ART_OFS_ADC: begin
               s_d.rdat[ART_ADC_W-1:0] = s_q.adc_res;
               s_d.rdat[ART_ADC_W]     = is_hi;
               s_d.rdat[ART_ADC_W+1]   = is_lo;
            end
            ART_OFS_STAT: begin
               s_d.rdat[ART_STAT_BUSY_BIT] = (s_q.st != ART_IDLE);
               s_d.rdat[ART_STAT_COMP_BIT] = s_q.comp; // see (R6)
            end
            ART_OFS_IRQ: begin
               s_d.rdat[ART_IRQ_W-1:0] = s_q.irq;
            end
            ART_OFS_MASK: begin
               s_d.rdat[ART_IRQ_W-1:0] = s_q.mask;
            end
            default: begin
               s_d.rdat = '0;
            end
         endcase
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         s_q          <= '0;
         s_q.st       <= ART_IDLE;
         s_q.code     <= ART_TRIM_RST;
         s_q.cal_code <= ART_TRIM_RST;
         s_q.mask     <= ART_MASK_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Outputs, all registered
   assign tmr_start                 = s_q.tmr_go;
   assign WB_ACK_OUT                = bus_ack;
   assign WB_DAT_OUT                = s_q.rdat;
   assign ADC_PHASE_SEL_OUT         = s_q.route; // see (R1)
   assign ADC_REL_MODE_OUT          = s_q.route; // see (R2)
   assign ADC_START_OUT             = s_q.adc_start;
   assign IRQ_OUT                   = s_q.irq_out;

   // ==========================================================
   // Pad drive: one control bit per binary weight feeds both groups,
   // so the two pad groups can never disagree
   for (genvar w = 0; w < ART_TRIM_W; w++) begin : g_weight
      assign TRIM_GROUP_A_SWITCHES_OUT[w] = s_q.sw[w]; // see (R5)
      assign TRIM_GROUP_B_SWITCHES_OUT[w] = s_q.sw[w]; // see (R5)
   end
endmodule // art_tuner

// *** bench/art_tuner_chk.sv ***
// Port checker of the antenna resonance tuner
`timescale 1ns/10ps
module art_tuner_chk
   import art_pkg::*;
#(
   parameter int SETTLE_CYC = ART_SETTLE_CYC
) (
   // Clock, reset and bus
   input wire logic                  REF_CLK_IN,
   input wire logic                  SYS_RST_IN,
   input wire logic                  WB_CYC_IN,
   input wire logic                  WB_STB_IN,
   input wire logic                  WB_WE_IN,
   input wire logic [3:0]            WB_SEL_IN,
   input wire logic [7:0]            WB_ADR_IN,
   input wire logic [31:0]           WB_DAT_IN,
   input wire logic [31:0]           WB_DAT_OUT,
   input wire logic                  WB_ACK_OUT,
   // Analog side and pads
   input wire logic                  ADC_PHASE_SEL_OUT,
   input wire logic                  ADC_REL_MODE_OUT,
   input wire logic                  ADC_START_OUT,
   input wire logic                  ADC_DONE_IN,
   input wire logic [ART_TRIM_W-1:0] TRIM_GROUP_A_SWITCHES_OUT,
   input wire logic [ART_TRIM_W-1:0] TRIM_GROUP_B_SWITCHES_OUT,
   input wire logic                  IRQ_OUT
);
   // ==========
   // Settle counter: cycles the trim code has held
   logic [ART_TRIM_W-1:0] last_q;
   logic [15:0]           held_q;
   always_ff @(posedge REF_CLK_IN) begin
      last_q <= TRIM_GROUP_A_SWITCHES_OUT;
      if (SYS_RST_IN || last_q != TRIM_GROUP_A_SWITCHES_OUT) begin
         held_q <= 16'h0;
      end else if (held_q != 16'hffff) begin
         held_q <= held_q + 16'h1;
      end
   end
   default clocking cb @(posedge REF_CLK_IN); endclocking
   default disable iff (SYS_RST_IN);
   // ==========
   // Assertions
   a_ack_next_cycle: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT
      |=> WB_ACK_OUT) else $error("request not acked next cycle");
   a_ack_single: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
      else $error("ack longer than one cycle");
   a_dat_idle_zero: assert property (!WB_ACK_OUT |-> WB_DAT_OUT == 32'h0)
      else $error("read data outside ack");
   a_groups_equal: assert property (
      TRIM_GROUP_A_SWITCHES_OUT == TRIM_GROUP_B_SWITCHES_OUT)
      else $error("pad groups differ");
   a_check_mode: assert property (ADC_START_OUT |->
      ADC_PHASE_SEL_OUT && ADC_REL_MODE_OUT)
      else $error("conversion without phase route");
   a_route_held: assert property (ADC_PHASE_SEL_OUT && !ADC_DONE_IN
      |=> ADC_PHASE_SEL_OUT && ADC_REL_MODE_OUT)
      else $error("phase route dropped early");
   a_start_pulse: assert property (ADC_START_OUT |=> !ADC_START_OUT)
      else $error("start longer than a pulse");
   a_cal_clears: assert property (WB_CYC_IN && WB_STB_IN
      && !WB_ACK_OUT && WB_SEL_IN[0] && WB_ADR_IN == ART_OFS_CMD && WB_WE_IN
      && WB_DAT_IN[ART_CMD_CAL_BIT] |-> ##[1:2]
      TRIM_GROUP_A_SWITCHES_OUT == 4'h0)
      else $error("trim not cleared at calibration start");
   a_step_settled: assert property (
      TRIM_GROUP_A_SWITCHES_OUT != 4'h0
      && TRIM_GROUP_A_SWITCHES_OUT == last_q + 4'h1
      |-> held_q >= 16'(SETTLE_CYC - 1))
      else $error("trim stepped before settle time");
   a_reset_quiet: assert property (disable iff (1'b0) SYS_RST_IN |=>
      !WB_ACK_OUT && !IRQ_OUT && TRIM_GROUP_A_SWITCHES_OUT == 4'h0)
      else $error("outputs active in reset");
   c_check: cover property (ADC_START_OUT);
   c_step: cover property (held_q == 16'h0 && last_q == 4'h2);
   c_irq: cover property ($rose(IRQ_OUT));
endmodule // art_tuner_chk

bind art_tuner art_tuner_chk #(.SETTLE_CYC(SETTLE_CYC)) i_chk (
   .REF_CLK_IN(REF_CLK_IN), .SYS_RST_IN(SYS_RST_IN),
   .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN),
   .WB_SEL_IN(WB_SEL_IN), .WB_ADR_IN(WB_ADR_IN), .WB_DAT_IN(WB_DAT_IN),
   .WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT),
   .ADC_PHASE_SEL_OUT(ADC_PHASE_SEL_OUT), .ADC_START_OUT(ADC_START_OUT),
   .ADC_REL_MODE_OUT(ADC_REL_MODE_OUT), .ADC_DONE_IN(ADC_DONE_IN),
   .TRIM_GROUP_A_SWITCHES_OUT(TRIM_GROUP_A_SWITCHES_OUT),
   .TRIM_GROUP_B_SWITCHES_OUT(TRIM_GROUP_B_SWITCHES_OUT),
   .IRQ_OUT(IRQ_OUT));

// *** bench/art_tank_model.sv ***
// Behavioural LC tank with trim capacitors and phase converter
`timescale 1ns/10ps
module art_tank_model
   import art_pkg::*;
#(
   parameter int CONV_CYC = 3
) (
   // Clock and tank setup
   input  wire logic                  clk_in,
   input  wire logic [4:0]            res_code_in,
   input  wire logic [ART_ADC_W-1:0]  phase_val_in,
   // Device side
   input  wire logic [ART_TRIM_W-1:0] trim_a_in,
   input  wire logic                  adc_start_in,
   output logic                       comp_out,
   output logic                       adc_done_out,
   output logic [ART_ADC_W-1:0]       adc_data_out
);
   int cnt;
   initial begin
      comp_out = 1'b0;
      adc_done_out = 1'b0;
      adc_data_out = 8'h00;
      cnt = 0;
   end
   // ==========
   // Codes below the resonant code leave the tank above target
   always @(posedge clk_in) begin
      comp_out <= {1'b0, trim_a_in} < res_code_in;
      adc_done_out <= 1'b0;
      // Stale data scrambled so a late read cannot pass
      adc_data_out <= ~adc_data_out;
      if (adc_start_in) begin
         cnt <= CONV_CYC;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end else if (cnt == 1) begin
         cnt <= 0;
         adc_done_out <= 1'b1;
         adc_data_out <= phase_val_in;
      end
   end
endmodule // art_tank_model

// *** bench/antenna_resonance_tuner_test.sv ***
// Self-checking bench of the antenna resonance tuner
`timescale 1ns/10ps
module antenna_resonance_tuner_test
   import art_pkg::*;
;
   localparam int SETTLE = 8;
   logic        clk, rst, cyc, stb, we, ack, comp, adone, psel, prel;
   logic        astart, irq;
   logic [3:0]  sel, trim_a, trim_b;
   logic [7:0]  adr, adata, phase;
   logic [31:0] wdat, rdat, rd;
   logic [4:0]  rcode;
   int          bad_count, total_checks;

   art_tuner #(.SETTLE_CYC(SETTLE)) i_dut (
      .REF_CLK_IN(clk), .SYS_RST_IN(rst), .WB_CYC_IN(cyc),
      .WB_STB_IN(stb), .WB_WE_IN(we), .WB_SEL_IN(sel), .WB_ADR_IN(adr),
      .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
      .PHASE_COMP_IN(comp), .ADC_PHASE_SEL_OUT(psel),
      .ADC_REL_MODE_OUT(prel), .ADC_START_OUT(astart),
      .ADC_DONE_IN(adone), .ADC_DATA_IN(adata),
      .TRIM_GROUP_A_SWITCHES_OUT(trim_a),
      .TRIM_GROUP_B_SWITCHES_OUT(trim_b), .IRQ_OUT(irq));
   art_tank_model i_tank (.clk_in(clk), .res_code_in(rcode),
      .phase_val_in(phase), .trim_a_in(trim_a), .adc_start_in(astart),
      .comp_out(comp), .adc_done_out(adone), .adc_data_out(adata));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ==========
   // Shared tasks
   task automatic fail(input string msg);
      bad_count++;
      $display("Error %0t: %s", $time, msg);
   endtask
   task automatic check(input logic [31:0] got, exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         fail($sformatf("%s got %h want %h", msg, got, exp));
      end
   endtask
   // Classic cycle; no fixed latency assumed, only a bounded wait
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
      int n;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) begin
         fail("no ack");
      end
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         bus(1'b0, ART_OFS_STAT, 32'h0, 4'hf);
         n++;
      end while (rd[ART_STAT_BUSY_BIT] !== 1'b0 && n < 200);
      if (n >= 200) begin
         fail("stuck busy");
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ==========
   // Scenarios
   task automatic t_reset();
      bus(1'b0, ART_OFS_MASK, 32'h0, 4'hf);
      check(rd, 32'(ART_MASK_RST), "mask reset");
      bus(1'b0, ART_OFS_CAL, 32'h0, 4'hf);
      check(rd, 32'(ART_TRIM_RST), "cal reset");
      check(32'(trim_a), 32'h0, "switches reset");
      $display("t_reset done");
   endtask
   task automatic t_check();
      logic [7:0] v [4] = '{8'h91, 8'h80, 8'h7f, 8'h6e};
      foreach (v[i]) begin
         phase <= v[i];
         bus(1'b1, ART_OFS_CMD, 32'h1, 4'h1);
         check({30'h0, psel, prel}, 32'h3, "phase route");
         wait_idle();
         check({30'h0, psel, prel}, 32'h0, "route released");
         bus(1'b0, ART_OFS_ADC, 32'h0, 4'hf);
         check(rd, {22'h0, v[i] < 8'h7f, v[i] > 8'h80, v[i]},
               "adc");
      end
      $display("t_check done");
   endtask
   task automatic t_cal(input logic [4:0] r, input logic [3:0] c,
                        input logic e);
      rcode <= r;
      bus(1'b1, ART_OFS_CMD, 32'h2, 4'h1);
      wait_idle();
      check(32'(rd[ART_STAT_COMP_BIT]), 32'(c < r), "comparator");
      bus(1'b0, ART_OFS_CAL, 32'h0, 4'hf);
      check(rd, {27'h0, e, c},
            "cal result");
      check(32'(trim_a), 32'(c), "switches");
      $display("t_cal %0d done", r);
   endtask
   task automatic t_irq();
      bus(1'b0, ART_OFS_IRQ, 32'h0, 4'hf);
      check(rd, 32'h7, "events");
      check(32'(irq), 32'h0, "masked irq");
      bus(1'b1, ART_OFS_MASK, 32'h4, 4'h1);
      check(32'(irq), 32'h1, "irq raised");
      bus(1'b1, ART_OFS_IRQ, 32'h4, 4'h1);
      check(32'(irq), 32'h0, "irq cleared");
      bus(1'b1, ART_OFS_IRQ, 32'h3, 4'h1);
      bus(1'b0, ART_OFS_IRQ, 32'h0, 4'hf);
      check(rd, 32'h0, "status cleared");
      $display("t_irq done");
   endtask
   task automatic t_ext();
      bus(1'b1, ART_OFS_EXTTRIM, 32'h1a, 4'h1);
      check(32'(trim_a), 32'ha, "ext a");
      check(32'(trim_b), 32'ha, "ext b");
      bus(1'b1, ART_OFS_EXTTRIM, 32'h15, 4'he);
      bus(1'b0, ART_OFS_EXTTRIM, 32'h0, 4'hf);
      check(rd, 32'h1a, "lane gated");
      bus(1'b1, ART_OFS_CMD, 32'h1, 4'h1);
      wait_idle();
      bus(1'b0, ART_OFS_CAL, 32'h0, 4'hf);
      check(rd, 32'h1, "cal kept");
      bus(1'b1, ART_OFS_EXTTRIM, 32'h0a, 4'h1);
      check(32'(trim_a), 32'h1, "cal code back");
      bus(1'b0, 8'h3c, 32'h0, 4'hf);
      check(rd, 32'h0, "unmapped");
      $display("t_ext done");
   endtask

   initial begin
      {cyc, stb, we, sel, adr, wdat, bad_count, total_checks} = '0;
      rst = 1'b1;
      phase = 8'h80;
      rcode = 5'h0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_check();
      t_cal(5'd0, 4'h0, 1'b1);
      t_cal(5'd5, 4'h5, 1'b0);
      t_cal(5'd16, 4'hf, 1'b1);
      t_cal(5'd1, 4'h1, 1'b0);
      t_irq();
      t_ext();
      complete_run();
   end
   initial begin
      #200000;
      fail("watchdog");
      complete_run();
   end
endmodule // antenna_resonance_tuner_test
